// ===== shared/dma_pkg.sv
package dma_pkg;

    // ****************************************************************
    // Sizes and register map
    // ****************************************************************
    localparam int NCH = 4;
    localparam int CH_SHIFT = 5;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_SEL = 3'h1;
    localparam logic [2:0] REG_STA = 3'h2;
    localparam logic [2:0] REG_STB = 3'h3;
    localparam logic [2:0] REG_PAD = 3'h4;
    localparam logic [2:0] REG_CNT = 3'h5;
    localparam logic [2:0] REG_STAT = 3'h6;

    // ****************************************************************
    // Control fields and status fields
    // ****************************************************************
    localparam int CTRL_EN = 0;
    localparam int CTRL_BYTE = 1;
    localparam int CTRL_DIR = 2;
    localparam int CTRL_HALF = 3;
    localparam int CTRL_AM = 4;
    localparam int CTRL_ONESHOT = 6;
    localparam int CTRL_PING = 7;
    localparam int CTRL_FORCE = 8;
    localparam logic [1:0] AM_INC = 2'h0;
    localparam logic [1:0] AM_FIX = 2'h1;
    localparam logic [1:0] AM_IND = 2'h2;
    localparam int STAT_PP = 16;
    localparam int STAT_PEND = 17;
    localparam int STAT_BUSY = 18;

    // ****************************************************************
    // Request source codes and peripheral addresses
    // ****************************************************************
    localparam logic [7:0] SRC_CAPTURE_ONE = 8'h01;
    localparam logic [7:0] SRC_CAPTURE_TWO = 8'h05;
    localparam logic [7:0] SRC_COMPARE_ONE = 8'h02;
    localparam logic [7:0] SRC_CAN_RX = 8'h22;
    localparam logic [7:0] SRC_CAN_TX = 8'h46;
    localparam logic [7:0] SRC_ADC_DONE = 8'h0D;
    localparam logic [15:0] ADDR_CAPTURE_ONE_BUFFER = 16'h0144;
    localparam logic [15:0] ADDR_COMPARE_ONE_PRIMARY = 16'h0906;
    localparam logic [15:0] ADDR_COMPARE_ONE_SECONDARY = 16'h0904;
    localparam logic [15:0] ADDR_CAN_RECEIVE_WORD = 16'h0440;
    localparam logic [15:0] ADDR_CONVERTER_RESULT_BUFFER = 16'h0300;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } fsm_e;

    typedef struct packed {
        logic req;
        logic we;
        logic byte_sz;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } mem_rsp_s;

    typedef struct packed {
        fsm_e fsm;
        logic [1:0] cur;
        logic [NCH-1:0][7:0] ctrl;
        logic [NCH-1:0][7:0] sel;
        logic [NCH-1:0][15:0] sta;
        logic [NCH-1:0][15:0] stb;
        logic [NCH-1:0][15:0] pad;
        logic [NCH-1:0][15:0] cnt;
        logic [NCH-1:0][15:0] done;
        logic [NCH-1:0][15:0] addr;
        logic [NCH-1:0] pp;
        logic [NCH-1:0] pend;
        logic [NCH-1:0] prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        mem_req_s mem;
        logic [NCH-1:0] irq_full;
        logic [NCH-1:0] irq_half;
    } state_s;

endpackage : dma_pkg

// ===== src/multichannel_dma_controller.sv
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// - Every channel moves data one way only, set by its direction bit.
// - Among simultaneous requesters a fixed channel-index order picks one.
// - Losing requesters stay pending and are served later.
// - Finishing a block pulses the channel's block interrupt.
// - A channel may also interrupt at half block, per its control bit.
// - Timer and external interrupt events can start transfers.
// - Post-increment mode steps the memory address after each element.
// - Fixed mode keeps the memory address unchanged.
// - Peripheral indirect mode takes the memory address from the peripheral.
// - Elements are bytes or 16-bit words, per channel.
// - A transfer starts by software force or by the selected request.
// - One-shot stops after a block; auto-repeat restarts it.
// - Ping-pong alternates two start addresses at each block end.
// - Each channel selects its request from any source by eight bits.
// - Capture sources use codes 01 and 05; first buffer at 0x0144.
// - First compare source uses code 02; registers at 0x0906, 0x0904.
// - CAN receive uses 22, transmit 46; receive word at 0x0440.
// - Conversion done uses code 0D; result read from 0x0300.
module multichannel_dma_controller (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [255:0] irq_src,
    input wire logic [15:0] pia_addr,
    output dma_pkg::mem_req_s mem_o,
    input wire dma_pkg::mem_rsp_s mem_i,
    output logic [dma_pkg::NCH-1:0] irq_block,
    output logic [dma_pkg::NCH-1:0] irq_half
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic reg_hit(input logic [31:0] a);
        return a[31:7] == 25'h0 && a[1:0] == 2'h0 &&
               a[4:2] <= dma_pkg::REG_STAT;
    endfunction : reg_hit

    function automatic logic [15:0] addr_step(input logic [7:0] c);
        return c[dma_pkg::CTRL_BYTE] ? 16'h0001 : 16'h0002;
    endfunction : addr_step

    function automatic logic [1:0] amode(input logic [7:0] c);
        return c[dma_pkg::CTRL_AM +: 2];
    endfunction : amode

    // Lowest index wins; bit 2 flags a winner.
    function automatic logic [2:0] arbitrate(input logic [3:0] p);
        logic [2:0] g;
        g = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (p[i]) begin
                g = {1'b1, 2'(i)};
            end
        end
        return g;
    endfunction : arbitrate

    // ****************************************************************
    // State and helpers
    // ****************************************************************
    dma_pkg::state_s r;
    dma_pkg::state_s s;
    logic [3:0] en;
    logic [3:0] src_now;
    logic [3:0] req_edge;
    logic [3:0] pend_ok;
    logic [2:0] grant;
    logic acc;
    logic wr;
    logic [1:0] wch;
    logic [2:0] wreg;
    logic elem_end;
    logic last;
    logic [7:0] cur_ctrl;
    logic [15:0] cur_addr;
    logic [15:0] cur_done;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            en[i] = r.ctrl[i][dma_pkg::CTRL_EN];
            src_now[i] = irq_src[r.sel[i]];
        end
    end

    assign req_edge = src_now & ~r.prev & en;
    assign pend_ok = r.pend & en;
    assign grant = arbitrate(pend_ok);
    assign acc = psel & penable;
    assign wr = acc & r.pready & pwrite & reg_hit(paddr);
    assign wch = paddr[6:5];
    assign wreg = paddr[4:2];
    assign cur_ctrl = r.ctrl[r.cur];
    assign cur_addr = r.addr[r.cur];
    assign cur_done = r.done[r.cur];
    assign last = cur_done == r.cnt[r.cur];
    assign elem_end = r.fsm == dma_pkg::ST_WRITE && mem_i.ack;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [3:0] set_m;
        logic [3:0] clr_m;
        logic [1:0] c;
        logic [15:0] st;
        set_m = req_edge;
        clr_m = 4'h0;
        c = r.cur;
        st = 16'h0;
        s = r;
        s.prev = src_now;
        s.irq_full = 4'h0;
        s.irq_half = 4'h0;

        // APB answers one cycle into the access phase.
        s.pready = acc & ~r.pready;
        s.pslverr = acc & ~r.pready & ~reg_hit(paddr);
        s.prdata = 32'h0;
        if (acc && !r.pready && reg_hit(paddr)) begin
            case (wreg)
                dma_pkg::REG_CTRL: s.prdata = {24'h0, r.ctrl[wch]};
                dma_pkg::REG_SEL: s.prdata = {24'h0, r.sel[wch]};
                dma_pkg::REG_STA: s.prdata = {16'h0, r.sta[wch]};
                dma_pkg::REG_STB: s.prdata = {16'h0, r.stb[wch]};
                dma_pkg::REG_PAD: s.prdata = {16'h0, r.pad[wch]};
                dma_pkg::REG_CNT: s.prdata = {16'h0, r.cnt[wch]};
                default: begin
                    s.prdata = {16'h0, r.done[wch]};
                    s.prdata[dma_pkg::STAT_PP] = r.pp[wch];
                    s.prdata[dma_pkg::STAT_PEND] = r.pend[wch];
                    s.prdata[dma_pkg::STAT_BUSY] =
                        r.fsm != dma_pkg::ST_IDLE && r.cur == wch;
                end
            endcase
        end

        if (wr) begin
            case (wreg)
                dma_pkg::REG_CTRL: begin
                    s.ctrl[wch] = pwdata[7:0];
                    if (pwdata[dma_pkg::CTRL_EN] && !en[wch]) begin
                        s.addr[wch] = r.sta[wch];
                        s.done[wch] = 16'h0;
                        s.pp[wch] = 1'b0;
                    end
                    if (pwdata[dma_pkg::CTRL_FORCE] &&
                        pwdata[dma_pkg::CTRL_EN]) begin
                        set_m[wch] = 1'b1;
                    end
                end
                dma_pkg::REG_SEL: s.sel[wch] = pwdata[7:0];
                dma_pkg::REG_STA: s.sta[wch] = pwdata[15:0];
                dma_pkg::REG_STB: s.stb[wch] = pwdata[15:0];
                dma_pkg::REG_PAD: s.pad[wch] = pwdata[15:0];
                dma_pkg::REG_CNT: s.cnt[wch] = pwdata[15:0];
                default: s.pend = r.pend;
            endcase
        end

        case (r.fsm)
            dma_pkg::ST_IDLE: begin
                if (grant[2]) begin
                    c = grant[1:0];
                    clr_m[c] = 1'b1;
                    s.cur = c;
                    s.fsm = dma_pkg::ST_READ;
                    st = r.addr[c];
                    if (amode(r.ctrl[c]) == dma_pkg::AM_IND) begin
                        st = pia_addr;
                        s.addr[c] = pia_addr;
                    end
                    s.mem.req = 1'b1;
                    s.mem.we = 1'b0;
                    s.mem.byte_sz = r.ctrl[c][dma_pkg::CTRL_BYTE];
                    s.mem.addr = r.ctrl[c][dma_pkg::CTRL_DIR] ?
                                 st : r.pad[c];
                end
            end
            dma_pkg::ST_READ: begin
                if (mem_i.ack) begin
                    s.fsm = dma_pkg::ST_WRITE;
                    s.mem.we = 1'b1;
                    s.mem.wdata = mem_i.rdata;
                    s.mem.addr = cur_ctrl[dma_pkg::CTRL_DIR] ?
                                 r.pad[c] : cur_addr;
                end
            end
            dma_pkg::ST_WRITE: begin
                if (mem_i.ack) begin
                    s.fsm = dma_pkg::ST_IDLE;
                    s.mem.req = 1'b0;
                    s.mem.we = 1'b0;
                    if (last) begin
                        s.irq_full[c] = 1'b1;
                        s.done[c] = 16'h0;
                        if (cur_ctrl[dma_pkg::CTRL_ONESHOT]) begin
                            s.ctrl[c][dma_pkg::CTRL_EN] = 1'b0;
                        end
                        if (cur_ctrl[dma_pkg::CTRL_PING]) begin
                            s.pp[c] = ~r.pp[c];
                            s.addr[c] = r.pp[c] ? r.sta[c] : r.stb[c];
                        end else begin
                            s.addr[c] = r.sta[c];
                        end
                    end else begin
                        s.done[c] = cur_done + 16'h0001;
                        if (cur_ctrl[dma_pkg::CTRL_HALF] &&
                            cur_done == {1'b0, r.cnt[c][15:1]}) begin
                            s.irq_half[c] = 1'b1;
                        end
                        if (amode(cur_ctrl) == dma_pkg::AM_INC) begin
                            s.addr[c] = cur_addr + addr_step(cur_ctrl);
                        end else begin
                            s.addr[c] = cur_addr;
                        end
                    end
                end
            end
            default: s.fsm = dma_pkg::ST_IDLE;
        endcase

        // A new request wins over the grant that clears the old one.
        s.pend = ((r.pend & ~clr_m) | set_m);
        for (int i = 0; i < 4; i++) begin
            if (!s.ctrl[i][dma_pkg::CTRL_EN]) begin
                s.pend[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.fsm <= dma_pkg::ST_IDLE;
        end else begin
            r <= s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign mem_o = r.mem;
    assign irq_block = r.irq_full;
    assign irq_half = r.irq_half;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_dir;
        r.fsm == dma_pkg::ST_READ && !cur_ctrl[dma_pkg::CTRL_DIR]
            |-> r.mem.addr == r.pad[r.cur] && !r.mem.we;
    endproperty
    a_dir: assert property (p_dir)
        else $error("peripheral read address wrong");

    property p_prio;
        r.fsm == dma_pkg::ST_IDLE && |pend_ok
            |=> r.fsm == dma_pkg::ST_READ &&
                ($past(pend_ok) & ((4'h1 << r.cur) - 4'h1)) == 4'h0;
    endproperty
    a_prio: assert property (p_prio)
        else $error("lower channel was pending but lost");

    property p_keep;
        r.fsm == dma_pkg::ST_IDLE && |pend_ok && !wr
            |=> ($past(pend_ok) & ~(4'h1 << r.cur) & ~r.pend) == 4'h0;
    endproperty
    a_keep: assert property (p_keep)
        else $error("losing request was dropped");

    property p_full;
        elem_end && last |=> r.irq_full == (4'h1 << r.cur);
    endproperty
    a_full: assert property (p_full)
        else $error("block interrupt missing");

    property p_half;
        elem_end && !last && cur_ctrl[dma_pkg::CTRL_HALF] &&
            cur_done == {1'b0, r.cnt[r.cur][15:1]}
            |=> r.irq_half == (4'h1 << r.cur) && r.irq_full == 4'h0;
    endproperty
    a_half: assert property (p_half)
        else $error("half block interrupt missing");

    property p_edge;
        req_edge != 4'h0 && !wr && !(elem_end && last)
            |=> (r.pend & $past(req_edge)) == $past(req_edge);
    endproperty
    a_edge: assert property (p_edge)
        else $error("selected source edge not latched");

    property p_inc;
        elem_end && !last && amode(cur_ctrl) == dma_pkg::AM_INC
            |=> cur_addr == $past(cur_addr) + $past(addr_step(cur_ctrl));
    endproperty
    a_inc: assert property (p_inc)
        else $error("address did not step");

    property p_fix;
        elem_end && !last && amode(cur_ctrl) == dma_pkg::AM_FIX
            |=> cur_addr == $past(cur_addr);
    endproperty
    a_fix: assert property (p_fix)
        else $error("fixed address moved");

    property p_size;
        r.mem.req |-> r.mem.byte_sz == cur_ctrl[dma_pkg::CTRL_BYTE];
    endproperty
    a_size: assert property (p_size)
        else $error("element size does not match channel");

    property p_once;
        elem_end && last && cur_ctrl[dma_pkg::CTRL_ONESHOT]
            |=> !en[r.cur] && !r.pend[r.cur];
    endproperty
    a_once: assert property (p_once)
        else $error("one-shot channel kept running");

    property p_ping;
        elem_end && last && cur_ctrl[dma_pkg::CTRL_PING]
            |=> r.pp[r.cur] != $past(r.pp[r.cur]);
    endproperty
    a_ping: assert property (p_ping)
        else $error("ping-pong buffer did not swap");

    property p_rearb;
        elem_end |=> r.fsm == dma_pkg::ST_IDLE && !r.mem.req;
    endproperty
    a_rearb: assert property (p_rearb)
        else $error("no return to arbitration after element");

    property p_wdir;
        r.fsm == dma_pkg::ST_WRITE && cur_ctrl[dma_pkg::CTRL_DIR]
            |-> r.mem.addr == r.pad[r.cur] && r.mem.we;
    endproperty
    a_wdir: assert property (p_wdir)
        else $error("peripheral write address wrong");

    property p_ind;
        r.fsm == dma_pkg::ST_IDLE && grant[2] &&
            amode(r.ctrl[grant[1:0]]) == dma_pkg::AM_IND
            |=> cur_addr == $past(pia_addr);
    endproperty
    a_ind: assert property (p_ind)
        else $error("peripheral supplied address not taken");

    property p_force;
        wr && wreg == dma_pkg::REG_CTRL && pwdata[dma_pkg::CTRL_FORCE] &&
            pwdata[dma_pkg::CTRL_EN]
            |=> r.pend[$past(wch)];
    endproperty
    a_force: assert property (p_force)
        else $error("software request not latched");

endmodule : multichannel_dma_controller

// ===== sim/mem_partner.sv
`timescale 1ns/10ps
// ****************************************************************
// Data memory and peripheral bus seen from the controller.
// ****************************************************************
module mem_partner (
    input wire logic clk,
    input wire logic rst,
    input wire dma_pkg::mem_req_s mem_o,
    output dma_pkg::mem_rsp_s mem_i
);
    int wait_n;

    // Each phase is answered after zero to two wait cycles, and read
    // data outside the answer cycle is scrambled so it cannot be reused.
    always @(posedge clk) begin
        if (rst) begin
            mem_i <= '0;
            wait_n <= 0;
        end else if (mem_i.ack) begin
            mem_i.ack <= 1'b0;
            mem_i.rdata <= ~mem_i.rdata;
            wait_n <= $urandom_range(2);
        end else if (mem_o.req && wait_n == 0) begin
            mem_i.ack <= 1'b1;
            mem_i.rdata <= mem_o.addr ^ 16'h5A3C;
        end else begin
            mem_i.rdata <= 16'($urandom);
            if (wait_n > 0) begin
                wait_n <= wait_n - 1;
            end
        end
    end
endmodule : mem_partner

// ===== sim/testbench.sv
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench for the four-channel controller.
// ****************************************************************
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [255:0] irq_src = '0;
    logic [15:0] pia_addr = '0;
    dma_pkg::mem_req_s mem_o;
    dma_pkg::mem_rsp_s mem_i;
    logic [dma_pkg::NCH-1:0] irq_block;
    logic [dma_pkg::NCH-1:0] irq_half;
    int fail_count = 0;
    int compares = 0;
    int nb[4];
    int nh[4];
    int eb[4];
    int eh[4];
    int m_ctrl[4];
    int m_sta[4];
    int m_stb[4];
    int m_pad[4];
    int m_cnt[4];
    int m_addr[4];
    int m_done[4];
    bit m_pp[4];
    bit m_on[4];
    logic [31:0] exp_q[$];
    bit exp_b[$];
    logic [31:0] e;
    logic [31:0] rd;
    logic err;
    bit b;
    // The last two codes are an external event and a timer.
    logic [7:0] codes[8] = '{dma_pkg::SRC_CAPTURE_ONE,
        dma_pkg::SRC_CAPTURE_TWO, dma_pkg::SRC_COMPARE_ONE,
        dma_pkg::SRC_CAN_RX, dma_pkg::SRC_CAN_TX, dma_pkg::SRC_ADC_DONE,
        8'h00, 8'h07};

    always #12.5 clk = ~clk;

    multichannel_dma_controller u_dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_src(irq_src), .pia_addr(pia_addr), .mem_o(mem_o),
        .mem_i(mem_i), .irq_block(irq_block), .irq_half(irq_half));

    mem_partner u_mem (.clk(clk), .rst(rst), .mem_o(mem_o), .mem_i(mem_i));

    // ****************************************************************
    // Checking and closing.
    // ****************************************************************
    task chk(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task close_out;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // ****************************************************************
    // Register bus master.
    // ****************************************************************
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic er);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task regw(input int ch, input logic [2:0] idx, input int d);
        apb(1'b1, 32'(ch * 32 + idx * 4), 32'(d), rd, err);
    endtask : regw

    // ****************************************************************
    // Reference model of the channels.
    // ****************************************************************
    task elem(input int ch);
        int mem;
        int src;
        int dst;
        if (!m_on[ch]) return;
        mem = (m_ctrl[ch][5:4] == 2) ? int'(pia_addr) : m_addr[ch];
        src = m_ctrl[ch][2] ? mem : m_pad[ch];
        dst = m_ctrl[ch][2] ? m_pad[ch] : mem;
        exp_q.push_back({dst[15:0], src[15:0] ^ 16'h5A3C});
        exp_b.push_back(m_ctrl[ch][1]);
        if (m_ctrl[ch][5:4] == 0) m_addr[ch] += m_ctrl[ch][1] ? 1 : 2;
        m_done[ch]++;
        if (m_ctrl[ch][3] && m_done[ch] == m_cnt[ch] / 2 + 1) eh[ch]++;
        if (m_done[ch] == m_cnt[ch] + 1) begin
            eb[ch]++;
            m_done[ch] = 0;
            m_pp[ch] ^= m_ctrl[ch][7];
            m_addr[ch] = m_pp[ch] ? m_stb[ch] : m_sta[ch];
            m_on[ch] = !m_ctrl[ch][6];
        end
    endtask : elem

    task cfg(input int ch, ctrl, sel, sta, stb, pad, cnt);
        regw(ch, dma_pkg::REG_CTRL, 0);
        regw(ch, dma_pkg::REG_SEL, sel);
        regw(ch, dma_pkg::REG_STA, sta);
        regw(ch, dma_pkg::REG_STB, stb);
        regw(ch, dma_pkg::REG_PAD, pad);
        regw(ch, dma_pkg::REG_CNT, cnt);
        m_ctrl[ch] = ctrl;
        m_sta[ch] = sta;
        m_stb[ch] = stb;
        m_pad[ch] = pad;
        m_cnt[ch] = cnt;
        m_addr[ch] = sta;
        m_done[ch] = 0;
        m_pp[ch] = 1'b0;
        m_on[ch] = 1'b1;
        if (ctrl[dma_pkg::CTRL_FORCE]) elem(ch);
        regw(ch, dma_pkg::REG_CTRL, ctrl);
    endtask : cfg

    task drain;
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("pending writes", exp_q.size(), 0);
        repeat (12) @(posedge clk);
    endtask : drain

    task pulse(input logic [7:0] code, input int chs);
        irq_src[code] <= 1'b1;
        @(posedge clk);
        irq_src[code] <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < 4; c++) begin
            if (chs[c]) elem(c);
        end
        drain();
    endtask : pulse

    task irqchk;
        for (int c = 0; c < 4; c++) begin
            chk("block irq count", nb[c], eb[c]);
            chk("half irq count", nh[c], eh[c]);
        end
    endtask : irqchk

    // ****************************************************************
    // Monitor of writes and interrupt pulses.
    // ****************************************************************
    always @(negedge clk) begin
        if (!rst) begin
            for (int c = 0; c < 4; c++) begin
                nb[c] += irq_block[c];
                nh[c] += irq_half[c];
            end
        end
        if (!rst && mem_o.req && mem_o.we && mem_i.ack) begin
            if (exp_q.size() == 0) begin
                chk("unrequested write", 1, 0);
            end else begin
                e = exp_q.pop_front();
                b = exp_b.pop_front();
                chk("write address", mem_o.addr, e[31:16]);
                chk("element size", mem_o.byte_sz, b);
                chk("write data", b ? mem_o.wdata[7:0] : mem_o.wdata,
                    b ? e[7:0] : e[15:0]);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'hE9404E11));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 32'h00000060, 32'h0, rd, err);
        chk("control after reset", rd, 32'h0);
        regw(0, dma_pkg::REG_SEL, dma_pkg::SRC_CAN_TX);
        apb(1'b0, 32'h00000004, 32'h0, rd, err);
        chk("source select", rd, 32'(dma_pkg::SRC_CAN_TX));
        apb(1'b1, 32'h0000003C, $urandom, rd, err);
        chk("unmapped error", err, 1'b1);
        $display("test registers done");
        cfg(0, 32'h49, dma_pkg::SRC_ADC_DONE, $urandom & 32'hFFFE, 0,
            dma_pkg::ADDR_CONVERTER_RESULT_BUFFER, 3);
        repeat (5) pulse(dma_pkg::SRC_ADC_DONE, 1);
        irqchk();
        $display("test word block one shot done");
        cfg(3, 32'h157, 0, $urandom & 32'hFFFE, 0,
            dma_pkg::ADDR_COMPARE_ONE_SECONDARY, 0);
        drain();
        irqchk();
        $display("test forced byte done");
        pia_addr <= 16'($urandom) & 16'hFFFE;
        cfg(2, 32'h21, dma_pkg::SRC_COMPARE_ONE, 0, 0,
            dma_pkg::ADDR_COMPARE_ONE_PRIMARY, 1);
        cfg(1, 32'h5, dma_pkg::SRC_COMPARE_ONE, $urandom & 32'hFFFE, 0,
            dma_pkg::ADDR_COMPARE_ONE_PRIMARY, 1);
        repeat (2) pulse(dma_pkg::SRC_COMPARE_ONE, 6);
        irqchk();
        $display("test arbitration done");
        cfg(3, 32'h81, dma_pkg::SRC_CAN_RX, $urandom & 32'hFFFE,
            $urandom & 32'hFFFE, dma_pkg::ADDR_CAN_RECEIVE_WORD, 0);
        repeat (3) pulse(dma_pkg::SRC_CAN_RX, 8);
        irqchk();
        $display("test ping pong done");
        for (int c = 1; c < 4; c++) begin
            regw(c, dma_pkg::REG_CTRL, 0);
            m_on[c] = 1'b0;
        end
        cfg(0, 32'h11, codes[0], $urandom & 32'hFFFE, 0,
            dma_pkg::ADDR_CAPTURE_ONE_BUFFER, 1);
        foreach (codes[i]) begin
            regw(0, dma_pkg::REG_SEL, codes[i]);
            pulse(codes[i], 1);
        end
        irqchk();
        $display("test source codes done");
        close_out();
    end
endmodule : testbench
